// ---- core/pwm_ctrl_regs.vh ----
/*
 Register offsets, field positions and reset values of the motor PWM
 control logic. Assumes a 32-bit APB with byte addresses, one register
 per aligned word.
*/
`ifndef PWM_CTRL_REGS_VH
`define PWM_CTRL_REGS_VH

`define CTL_ONE_OFS 8'h00
`define CTL_TWO_OFS 8'h04
`define CNT_HIGH_OFS 8'h08
`define CNT_LOW_OFS 8'h0c
`define MOD_HIGH_OFS 8'h10
`define MOD_LOW_OFS 8'h14
`define DUTY_BASE_OFS 8'h18
`define DUTY_LAST_OFS 8'h44
`define CONFIG_OFS 8'h48
`define DIS_MAP_OFS 8'h4c
`define FAULT_OFS 8'h50
`define MANUAL_OFS 8'h54

`define C1_EN_BIT 0
`define C1_LOAD_PERMIT_BIT 1
`define C1_FLAG_BIT 4
`define C1_IRQEN_BIT 5
`define C1_BANK_Y_DISABLE_BIT 6
`define C1_BANK_X_DISABLE_BIT 7

`define C2_PSC_LSB 0
`define C2_PAIR_ONE_VALUE_SELECT_BIT 2
`define C2_SEL34_BIT 3
`define C2_SEL56_BIT 4
`define C2_RATE_LSB 6

`define CFG_CENTER_BIT 0
`define CFG_COMPL_BIT 1
`define MAP_Y_LSB 8
`define FLT_LVL_LSB 2
`define MAN_SEL_BIT 7

`define CTL_TWO_RST 8'h00
`define CONFIG_RST 8'h03
`define DUTY_RST 16'h0000

`endif

// ---- core/pwm_pair.v ----
/*
 One output pair of the generator: two duty comparators with optional
 complementary operation. Assumes counter and modulus from the caller.
*/
`timescale 1ns/1ps
module pwm_pair (
   // Timebase
   input wire [11:0] count,
   input wire [11:0] modulus,
   // Duty values and mode
   input wire [15:0] duty_top,
   input wire [15:0] duty_bottom,
   input wire use_bottom,
   input wire complementary,
   // Levels before masking
   output wire level_top,
   output wire level_bottom
);
   wire [15:0] shared;
   wire on_top;
   wire on_bot;

   // Pairs share one value in complementary mode
   assign shared = use_bottom ? duty_bottom : duty_top;

   function cmp;
      input [15:0] duty;
      input [11:0] cnt;
      input [11:0] md;
      begin
         if ($signed(duty) <= $signed(16'h0000))
            cmp = 1'b0;
         else if ($signed(duty) >= $signed({4'h0, md}))
            cmp = 1'b1;
         else
            cmp = {4'h0, cnt} < duty;
      end
   endfunction

   assign on_top = cmp(complementary ? shared : duty_top, count, modulus);
   assign on_bot = cmp(duty_bottom, count, modulus);
   assign level_top = on_top;
   // No dead-time here; in complementary mode the bottom switch is the plain complement
   assign level_bottom = complementary ? ~on_top : on_bot;
endmodule

// ---- core/motor_pwm_control_logic.v ----
/*
 Control logic of a six-channel motor PWM generator with APB register
 access. Assumes break_mode and break_clear_enable come from logic on
 pclk; fault pins are asynchronous and synchronised here.
*/
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "pwm_ctrl_regs.vh"

module motor_pwm_control_logic (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Debug control
   input wire break_mode,
   input wire break_clear_enable,
   // Fault pins, active high
   input wire [1:0] fault_pin,
   // Power stage pins
   output reg [5:0] pwm_out,
   output reg [5:0] pwm_oe,
   // Reload interrupt
   output reg reload_irq
);
   reg generator_enable_q, load_permit_q, reload_flag_q;
   reg reload_irq_enable_q, bank_x_disable_q, bank_y_disable_q;
   reg [7:0] ctl_two_q;
   reg [11:0] mod_buf_q, mod_act_q;
   reg [15:0] duty_buf_q [0:5];
   reg [15:0] duty_act_q [0:5];
   reg [1:0] psc_act_q, rate_act_q;
   reg [2:0] sel_act_q;
   reg center_q, compl_q;
   reg [5:0] map_x_q, map_y_q;
   reg [5:0] man_out_q;
   reg manual_output_select_q;
   reg [11:0] cnt_q;
   reg down_q;
   reg [2:0] div_q, rcnt_q;
   reg en_prev_q, armed_q;
   reg [7:0] low_latch_q;
   reg latched_q;
   reg [1:0] flt_s1_q, flt_s2_q, flt_s3_q;
   reg [1:0] fault_event_flag_q, flt_hold_q;
   reg dis_x_act_q, dis_y_act_q;
   reg [31:0] rd_d;
   reg err_d;
   reg reload_flag_d;
   integer i, j, k;

   wire acc = psel & penable & pready;
   wire wr = acc & pwrite;
   wire rd = acc & ~pwrite;
   wire [7:0] ofs = paddr[7:0];
   wire [7:0] doff = ofs - `DUTY_BASE_OFS;
   wire [2:0] didx = doff[5:3];
   wire duty_hit = (ofs >= `DUTY_BASE_OFS) && (ofs <= `DUTY_LAST_OFS)
      && (ofs[1:0] == 2'b00) && (paddr[31:8] == 24'h000000);
   wire clr_ok = ~break_mode | break_clear_enable;

   // Generator runs only while enabled and not in break
   wire run = generator_enable_q & ~break_mode;
   wire [2:0] pmask = {psc_act_q == 2'd3, psc_act_q[1], |psc_act_q};
   wire tick = run && ((div_q & pmask) == pmask);
   wire [2:0] rlim = {rate_act_q == 2'd3, rate_act_q[1], |rate_act_q};
   wire mod_zero = (mod_act_q == 12'h000);
   wire [11:0] cnt_inc = cnt_q + 12'h001;
   wire [11:0] cnt_dec = cnt_q - 12'h001;
   wire at_end = mod_zero ? (cnt_q == 12'h000) :
      center_q ? (down_q && cnt_q == 12'h001) :
      (cnt_inc >= mod_act_q);
   wire boundary = tick & at_end;
   wire first = generator_enable_q & ~en_prev_q & ~break_mode;
   wire reload = first | (boundary & (rcnt_q == rlim));

   wire [1:0] flt_lvl = flt_s2_q & flt_s3_q;
   wire [5:0] gen_lvl;
   wire [5:0] mask = ({6{dis_x_act_q}} & map_x_q)
      | ({6{dis_y_act_q}} & map_y_q)
      | ({6{flt_hold_q[0] | flt_lvl[0]}} & map_x_q)
      | ({6{flt_hold_q[1] | flt_lvl[1]}} & map_y_q);

   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : pair
         pwm_pair u_pair (
            .count(cnt_q),
            .modulus(mod_act_q),
            .duty_top(duty_act_q[2*g]),
            .duty_bottom(duty_act_q[2*g+1]),
            .use_bottom(sel_act_q[g]),
            .complementary(compl_q),
            .level_top(gen_lvl[2*g]),
            .level_bottom(gen_lvl[2*g+1])
         );
      end
   endgenerate

   // Read mux and unmapped detection, captured in setup phase
   always @* begin
      rd_d = 32'h00000000;
      err_d = 1'b0;
      if (duty_hit) begin
         if (doff[2])
            rd_d[7:0] = duty_buf_q[didx][7:0];
         else
            rd_d[7:0] = duty_buf_q[didx][15:8];
      end else if (paddr[31:8] != 24'h000000) begin
         err_d = 1'b1;
      end else begin
         case (ofs)
            `CTL_ONE_OFS: begin
               rd_d[`C1_EN_BIT] = generator_enable_q;
               rd_d[`C1_LOAD_PERMIT_BIT] = load_permit_q;
               rd_d[`C1_FLAG_BIT] = reload_flag_q;
               rd_d[`C1_IRQEN_BIT] = reload_irq_enable_q;
               rd_d[`C1_BANK_Y_DISABLE_BIT] = bank_y_disable_q;
               rd_d[`C1_BANK_X_DISABLE_BIT] = bank_x_disable_q;
            end
            `CTL_TWO_OFS: rd_d[7:0] = ctl_two_q;
            `CNT_HIGH_OFS: rd_d[3:0] = cnt_q[11:8];
            `CNT_LOW_OFS: rd_d[7:0] = latched_q ? low_latch_q : cnt_q[7:0];
            `MOD_HIGH_OFS: rd_d[3:0] = mod_buf_q[11:8];
            `MOD_LOW_OFS: rd_d[7:0] = mod_buf_q[7:0];
            `CONFIG_OFS: begin
               rd_d[`CFG_CENTER_BIT] = center_q;
               rd_d[`CFG_COMPL_BIT] = compl_q;
            end
            `DIS_MAP_OFS: begin
               rd_d[5:0] = map_x_q;
               rd_d[`MAP_Y_LSB+5:`MAP_Y_LSB] = map_y_q;
            end
            `FAULT_OFS: begin
               rd_d[1:0] = fault_event_flag_q;
               rd_d[`FLT_LVL_LSB+1:`FLT_LVL_LSB] = flt_lvl;
            end
            `MANUAL_OFS: begin
               rd_d[5:0] = man_out_q;
               rd_d[`MAN_SEL_BIT] = manual_output_select_q;
            end
            default: err_d = 1'b1;
         endcase
      end
   end

   // Flag: hardware set wins over the clear sequence
   always @* begin
      reload_flag_d = reload_flag_q;
      if (wr && ofs == `CTL_ONE_OFS && !pwdata[`C1_FLAG_BIT] && armed_q
            && clr_ok)
         reload_flag_d = 1'b0;
      if (reload)
         reload_flag_d = 1'b1;
   end

   // APB handshake, no wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= psel & ~penable & ~pready;
         // Error stands only in the access cycle
         pslverr <= psel & ~penable & err_d;
         if (psel & ~penable) begin
            prdata <= pwrite ? 32'h00000000 : rd_d;
         end
      end
   end

   // Modulus has no reset by design
   always @(posedge pclk) begin
      if (wr && ofs == `MOD_HIGH_OFS)
         mod_buf_q[11:8] <= pwdata[3:0];
      if (wr && ofs == `MOD_LOW_OFS)
         mod_buf_q[7:0] <= pwdata[7:0];
      if (reload && load_permit_q)
         mod_act_q <= mod_buf_q;
   end

   // Control registers and buffers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         generator_enable_q <= 1'b0;
         load_permit_q <= 1'b0;
         reload_flag_q <= 1'b0;
         reload_irq_enable_q <= 1'b0;
         bank_x_disable_q <= 1'b0;
         bank_y_disable_q <= 1'b0;
         ctl_two_q <= `CTL_TWO_RST;
         center_q <= (`CONFIG_RST & (8'h01 << `CFG_CENTER_BIT)) != 8'h00;
         compl_q <= (`CONFIG_RST & (8'h01 << `CFG_COMPL_BIT)) != 8'h00;
         map_x_q <= 6'h00;
         map_y_q <= 6'h00;
         man_out_q <= 6'h00;
         manual_output_select_q <= 1'b0;
         armed_q <= 1'b0;
         low_latch_q <= 8'h00;
         latched_q <= 1'b0;
         reload_irq <= 1'b0;
         for (i = 0; i < 6; i = i + 1)
            duty_buf_q[i] <= `DUTY_RST;
      end else begin
         reload_flag_q <= reload_flag_d;
         reload_irq <= reload_flag_d & reload_irq_enable_q;
         if (reload)
            armed_q <= 1'b0;
         else if (rd && ofs == `CTL_ONE_OFS && reload_flag_q)
            armed_q <= 1'b1;
         else if (wr && ofs == `CTL_ONE_OFS)
            armed_q <= 1'b0;
         // Latch where the high byte is captured, so both halves match
         if (psel && !penable && !pwrite && ofs == `CNT_HIGH_OFS) begin
            low_latch_q <= cnt_q[7:0];
            latched_q <= 1'b1;
         end else if (rd && ofs == `CNT_LOW_OFS) begin
            latched_q <= 1'b0;
         end
         if (wr && ofs == `CTL_ONE_OFS) begin
            generator_enable_q <= pwdata[`C1_EN_BIT];
            reload_irq_enable_q <= pwdata[`C1_IRQEN_BIT];
            bank_x_disable_q <= pwdata[`C1_BANK_X_DISABLE_BIT];
            bank_y_disable_q <= pwdata[`C1_BANK_Y_DISABLE_BIT];
         end
         // Transfer uses the old permit; a same-cycle write 0 comes too late to stop it
         if (wr && ofs == `CTL_ONE_OFS)
            load_permit_q <= pwdata[`C1_LOAD_PERMIT_BIT];
         else if (reload && load_permit_q)
            load_permit_q <= 1'b0;
         if (wr && ofs == `CTL_TWO_OFS)
            ctl_two_q <= pwdata[7:0];
         if (wr && ofs == `CONFIG_OFS) begin
            center_q <= pwdata[`CFG_CENTER_BIT];
            compl_q <= pwdata[`CFG_COMPL_BIT];
         end
         if (wr && ofs == `DIS_MAP_OFS) begin
            map_x_q <= pwdata[5:0];
            map_y_q <= pwdata[`MAP_Y_LSB+5:`MAP_Y_LSB];
         end
         if (wr && ofs == `MANUAL_OFS) begin
            man_out_q <= pwdata[5:0];
            manual_output_select_q <= pwdata[`MAN_SEL_BIT];
         end
         if (wr && duty_hit) begin
            if (doff[2])
               duty_buf_q[didx][7:0] <= pwdata[7:0];
            else
               duty_buf_q[didx][15:8] <= pwdata[7:0];
         end
      end
   end

   // Counter, prescaler, reload scheduling and active values
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 12'h000;
         down_q <= 1'b0;
         div_q <= 3'b000;
         rcnt_q <= 3'b000;
         en_prev_q <= 1'b0;
         psc_act_q <= 2'b00;
         rate_act_q <= 2'b00;
         sel_act_q <= 3'b000;
         for (j = 0; j < 6; j = j + 1)
            duty_act_q[j] <= `DUTY_RST;
      end else begin
         if (!break_mode)
            en_prev_q <= generator_enable_q;
         if (!generator_enable_q) begin
            // Stopped counter restarts cleanly on the next enable
            cnt_q <= 12'h000;
            down_q <= 1'b0;
            div_q <= 3'b000;
            rcnt_q <= 3'b000;
         end else if (run) begin
            div_q <= tick ? 3'b000 : div_q + 3'b001;
            if (first) begin
               cnt_q <= 12'h000;
               down_q <= 1'b0;
               rcnt_q <= 3'b000;
            end else if (tick) begin
               if (mod_zero) begin
                  cnt_q <= cnt_dec;
               end else if (center_q) begin
                  cnt_q <= down_q ? cnt_dec : cnt_inc;
                  if (!down_q && cnt_inc >= mod_act_q)
                     down_q <= 1'b1;
                  else if (down_q && cnt_q == 12'h001)
                     down_q <= 1'b0;
               end else begin
                  cnt_q <= at_end ? 12'h000 : cnt_inc;
               end
               if (boundary)
                  rcnt_q <= (rcnt_q == rlim) ? 3'b000 : rcnt_q + 3'b001;
            end
         end
         if (boundary | first)
            sel_act_q <= ctl_two_q[`C2_SEL56_BIT:`C2_PAIR_ONE_VALUE_SELECT_BIT];
         if (reload) begin
            rate_act_q <= ctl_two_q[`C2_RATE_LSB+1:`C2_RATE_LSB];
            if (load_permit_q) begin
               psc_act_q <= ctl_two_q[`C2_PSC_LSB+1:`C2_PSC_LSB];
               for (j = 0; j < 6; j = j + 1)
                  duty_act_q[j] <= duty_buf_q[j];
            end
         end
      end
   end

   // Fault path keeps its clock through break
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flt_s1_q <= 2'b00;
         flt_s2_q <= 2'b00;
         flt_s3_q <= 2'b00;
         fault_event_flag_q <= 2'b00;
         flt_hold_q <= 2'b00;
      end else begin
         flt_s1_q <= fault_pin;
         flt_s2_q <= flt_s1_q;
         flt_s3_q <= flt_s2_q;
         for (k = 0; k < 2; k = k + 1) begin
            if (flt_lvl[k] && !flt_hold_q[k])
               fault_event_flag_q[k] <= 1'b1;
            else if (wr && ofs == `FAULT_OFS && pwdata[k] && clr_ok)
               fault_event_flag_q[k] <= 1'b0;
            if (flt_lvl[k])
               flt_hold_q[k] <= 1'b1;
            else if (boundary | ~generator_enable_q)
               flt_hold_q[k] <= 1'b0;
         end
      end
   end

   // Bank disables and pin drivers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dis_x_act_q <= 1'b0;
         dis_y_act_q <= 1'b0;
         pwm_out <= 6'h00;
         pwm_oe <= 6'h00;
      end else begin
         if (bank_x_disable_q)
            dis_x_act_q <= 1'b1;
         else if (boundary | ~generator_enable_q)
            dis_x_act_q <= 1'b0;
         if (bank_y_disable_q)
            dis_y_act_q <= 1'b1;
         else if (boundary | ~generator_enable_q)
            dis_y_act_q <= 1'b0;
         if (break_mode) begin
            pwm_out <= pwm_out & ~mask;
         end else begin
            pwm_oe <= {6{generator_enable_q | manual_output_select_q}};
            if (manual_output_select_q)
               pwm_out <= man_out_q & ~mask;
            else if (generator_enable_q)
               pwm_out <= gen_lvl & ~mask;
            else
               pwm_out <= 6'h00;
         end
      end
   end
endmodule

// ---- sim/pwm_stage_model.sv ----
/*
 Power stage model: one gate driver input per switch, each with a
 pull-down. Assumes pin levels and enables from the control logic.
*/
`timescale 1ns/1ps
module pwm_stage_model (
   // Pins from the control logic
   input wire [5:0] pwm_out,
   input wire [5:0] pwm_oe,
   // Switch states seen by the motor
   output wire [5:0] switch_on
);
   // Pull-downs: a floating pin never turns a switch on
   assign switch_on = pwm_out & pwm_oe;
endmodule

// ---- sim/pwm_ctrl_checker.sv ----
/*
 Checker of the motor PWM control logic, bound onto its top module.
 Assumes one clock domain and the register map of the header.
*/
`timescale 1ns/1ps
`include "pwm_ctrl_regs.vh"
module pwm_ctrl_checker (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   // Debug, faults, pins
   input wire break_mode,
   input wire break_clear_enable,
   input wire [1:0] fault_pin,
   input wire [5:0] pwm_out,
   input wire [5:0] pwm_oe,
   input wire reload_irq
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_all = psel && penable && pready && pwrite;
   wire wr_one = wr_all && paddr == {24'h000000, `CTL_ONE_OFS};
   wire wr_noen = wr_one && !pwdata[`C1_IRQEN_BIT];
   reg armed_q;
   // Any completed write may enable the pins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         armed_q <= 1'b0;
      else if (wr_all)
         armed_q <= 1'b1;
   end
   AST_APB_ANSWER: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_READY_ONE: assert property (pready |-> (psel && penable) ##1 !pready)
      else $error("ready outside one access cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_UNMAPPED_READ: assert property (psel && !penable && !pwrite &&
      paddr[31:8] != 24'h000000 |=> pslverr && prdata == 32'h00000000)
      else $error("unmapped read not refused");
   AST_BREAK_FREEZE: assert property (
      (break_mode && fault_pin == 2'b00) [*4] |-> $stable(pwm_out) &&
      $stable(pwm_oe)) else $error("pins moved in break");
   AST_IRQ_FALL: assert property (
      $fell(reload_irq) |-> $past(wr_one) || $past(wr_one, 2))
      else $error("reload irq fell without a write");
   AST_BREAK_GUARD: assert property ($fell(reload_irq) &&
      $past(break_mode) && !$past(break_clear_enable) |->
      $past(wr_noen) || $past(wr_noen, 2))
      else $error("reload flag cleared in guarded break");
   AST_PINS_QUIET: assert property (!armed_q |-> pwm_oe == 6'h00)
      else $error("pins driven before any write");
endmodule

bind motor_pwm_control_logic pwm_ctrl_checker pwm_ctrl_checker_i (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .break_mode, .break_clear_enable, .fault_pin,
   .pwm_out, .pwm_oe, .reload_irq);

// ---- sim/motor_pwm_control_logic_tb.sv ----
/*
 Testbench of the motor PWM control logic: APB master tasks, power
 stage model, one task per scenario. Assumes a 25 MHz clock.
*/
`timescale 1ns/1ps
`include "pwm_ctrl_regs.vh"
module motor_pwm_control_logic_tb;
   reg pclk, presetn, psel, penable, pwrite, err;
   reg [31:0] paddr, pwdata, q;
   wire [31:0] prdata;
   wire pready, pslverr, reload_irq;
   reg break_mode, break_clear_enable;
   reg [1:0] fault_pin;
   wire [5:0] pwm_out, pwm_oe, switch_on;
   reg [23:0] page;
   int fail_count = 0, samples_checked = 0, cyc = 0;
   reg [31:0] g;
   motor_pwm_control_logic motor_pwm_control_logic_i (.pclk, .presetn,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .break_mode, .break_clear_enable, .fault_pin, .pwm_out,
      .pwm_oe, .reload_irq);
   pwm_stage_model pwm_stage_model_i (.pwm_out, .pwm_oe, .switch_on);
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) cyc <= cyc + 1;
   task check(input [31:0] seen, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task apb(input wr, input [7:0] a, input [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {page, a};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a missing answer
      while (pready !== 1'b1)
         @(posedge pclk);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input [7:0] a, input [7:0] d);
      apb(1'b1, a, {24'h000000, d});
   endtask
   task rd(input [7:0] a);
      apb(1'b0, a, 32'h00000000);
   endtask
   task duty(input [2:0] n, input [15:0] v);
      wr(`DUTY_BASE_OFS + {2'b00, n, 3'b000}, v[15:8]);
      wr(`DUTY_BASE_OFS + {2'b00, n, 3'b000} + 8'h04, v[7:0]);
   endtask
   task on_count(input [2:0] ch, input int exp);
      reg [31:0] k;
      k = 0;
      repeat (32) begin
         @(posedge pclk);
         k = k + switch_on[ch];
      end
      check(k, exp);
   endtask
   // Bounded: a silent reload flag must not hang the run
   task wait_irq(input v);
      int n;
      n = 0;
      while (reload_irq !== v && n < 2000) begin
         n = n + 1;
         @(posedge pclk);
      end
      check(32'(n < 2000), 32'h1);
   endtask
   // Clear sequence, then wait for the next reload
   task reload_wait;
      rd(`CTL_ONE_OFS);
      wr(`CTL_ONE_OFS, 8'h23);
      @(posedge pclk);
      // A reload between read and write keeps the flag; retry once
      if (reload_irq === 1'b1) begin
         rd(`CTL_ONE_OFS);
         wr(`CTL_ONE_OFS, 8'h23);
      end
      wait_irq(1'b0);
      wait_irq(1'b1);
   endtask
   task t_regs;
      check(pwm_oe, 6'h00);
      rd(`CTL_TWO_OFS);
      check(q, `CTL_TWO_RST);
      rd(`CONFIG_OFS);
      check(q, `CONFIG_RST);
      rd(`DUTY_BASE_OFS + 8'h04);
      check(q, 32'h0);
      wr(`MOD_HIGH_OFS, 8'h00);
      wr(`MOD_LOW_OFS, 8'h10);
      rd(`MOD_LOW_OFS);
      check(q, 32'h10);
      wr(`CONFIG_OFS, 8'h00);
      wr(`DIS_MAP_OFS, 8'h3f);
      page = 24'h000001;
      rd(`CTL_ONE_OFS);
      check({err, q[30:0]}, 32'h80000000);
      page = 24'h000000;
   endtask
   task t_duty;
      duty(0, 16'h0008);
      duty(1, 16'h0000);
      duty(2, 16'hfffc);
      duty(3, 16'h0010);
      duty(4, 16'h7fff);
      duty(5, 16'h8000);
      rd(8'h2c);
      check(q, 32'hfc);
      wr(`CTL_ONE_OFS, 8'h03);
      rd(`CTL_ONE_OFS);
      check(q & 32'h13, 32'h11);
      check(pwm_oe, 6'h3f);
      on_count(0, 16);
      on_count(1, 0);
      on_count(2, 0);
      on_count(3, 32);
      on_count(4, 32);
      on_count(5, 0);
   endtask
   task t_counter;
      rd(`CNT_HIGH_OFS);
      rd(`CNT_LOW_OFS);
      g = q;
      rd(`CNT_LOW_OFS);
      check((q - g) & 32'hf, 32'h6);
   endtask
   // Break holds off load cycles, so the cancel cannot race one
   task t_load_permit;
      duty(0, 16'h0010);
      repeat (40) @(posedge pclk);
      on_count(0, 16);
      break_mode <= 1'b1;
      wr(`CTL_ONE_OFS, 8'h03);
      wr(`CTL_ONE_OFS, 8'h01);
      break_mode <= 1'b0;
      repeat (40) @(posedge pclk);
      on_count(0, 16);
      wr(`CTL_ONE_OFS, 8'h03);
      repeat (40) @(posedge pclk);
      on_count(0, 32);
   endtask
   task t_irq;
      repeat (40) @(posedge pclk);
      check(reload_irq, 1'b0);
      rd(`CTL_ONE_OFS);
      check(q[4], 1'b1);
      wr(`CTL_ONE_OFS, 8'h21);
      wait_irq(1'b1);
      rd(`CTL_ONE_OFS);
      repeat (17) @(posedge pclk);
      wr(`CTL_ONE_OFS, 8'h21);
      rd(`CTL_ONE_OFS);
      check(q[4], 1'b1);
   endtask
   task t_rates;
      for (int i = 0; i < 4; i = i + 1) begin
         wr(`CTL_TWO_OFS, 8'(i * 65));
         rd(`CTL_TWO_OFS);
         check(q, i * 65);
         reload_wait;
         reload_wait;
         g = cyc;
         reload_wait;
         check(cyc - g, 16 << (2 * i));
      end
      wr(`CTL_TWO_OFS, 8'h00);
      reload_wait;
      reload_wait;
   endtask
   task t_comp;
      wr(`CONFIG_OFS, 8'h02);
      duty(0, 16'h0000);
      duty(1, 16'h0010);
      wr(`CTL_ONE_OFS, 8'h23);
      repeat (40) @(posedge pclk);
      check(switch_on[1:0], 2'b10);
      wr(`CTL_TWO_OFS, 8'h04);
      repeat (40) @(posedge pclk);
      check(switch_on[1:0], 2'b01);
      wr(`CONFIG_OFS, 8'h00);
      wr(`CTL_TWO_OFS, 8'h00);
      wr(`CTL_ONE_OFS, 8'ha1);
      repeat (3) @(posedge pclk);
      check(switch_on, 6'h00);
      wr(`CTL_ONE_OFS, 8'h21);
      repeat (20) @(posedge pclk);
      check(switch_on, 6'h1a);
      wr(`MANUAL_OFS, 8'h85);
      repeat (2) @(posedge pclk);
      check(switch_on, 6'h05);
      wr(`MANUAL_OFS, 8'h00);
      // Center mode: period twice the modulus
      wr(`CONFIG_OFS, 8'h01);
      duty(0, 16'h0008);
      reload_wait;
      g = cyc;
      reload_wait;
      check(cyc - g, 32'd32);
      on_count(0, 15);
   endtask
   task t_break;
      wait_irq(1'b1);
      break_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      q = switch_on;
      repeat (20) @(posedge pclk);
      check(switch_on, q[5:0]);
      rd(`CTL_ONE_OFS);
      wr(`CTL_ONE_OFS, 8'h21);
      repeat (3) @(posedge pclk);
      check(reload_irq, 1'b1);
      break_clear_enable <= 1'b1;
      rd(`CTL_ONE_OFS);
      wr(`CTL_ONE_OFS, 8'h21);
      repeat (3) @(posedge pclk);
      check(reload_irq, 1'b0);
      fault_pin <= 2'b01;
      repeat (8) @(posedge pclk);
      check(switch_on, 6'h00);
      break_mode <= 1'b0;
      break_clear_enable <= 1'b0;
      fault_pin <= 2'b00;
      rd(`FAULT_OFS);
      check(q[0], 1'b1);
      reload_wait;
      rd(`FAULT_OFS);
      check(q[0], 1'b1);
      wr(`FAULT_OFS, 8'h01);
      rd(`FAULT_OFS);
      check(q[1:0], 2'b00);
   endtask
   task end_of_test;
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 32'h0;
      pwdata = 32'h0;
      page = 24'h000000;
      break_mode = 1'b0;
      break_clear_enable = 1'b0;
      fault_pin = 2'b00;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_duty;
      t_counter;
      t_load_permit;
      t_irq;
      t_rates;
      t_comp;
      t_break;
      end_of_test;
   end
   // Whole run needs well under 10000 cycles
   initial begin
      #(40 * 30000);
      fail_count = fail_count + 1;
      end_of_test;
   end
endmodule
